// File: hdl/slpg_gate.sv
/*
 per-peripheral clock enables and access blocking.
 assumes the sleep controller says whether peripheral clocks run at all.
*/
`timescale 1ns/10ps
module slpg_gate #(
    parameter int N = 8
) (
    input wire logic i_clk,            // main clock
    input wire logic i_rst,            // sync reset
    input wire logic i_io_run,         // io clock domain running
    input wire logic [N-1:0] i_stop,   // clock-stop bits
    input wire logic [N-1:0] i_acc,    // register access attempts
    output logic [N-1:0] o_clk_en,     // peripheral clock enables
    output logic [N-1:0] o_acc_ok      // accesses allowed through
);
    typedef struct packed {
        logic [N-1:0] en;
        logic [N-1:0] ok;
    } slpg_gate_t;
    slpg_gate_t st_reg, st_next;
    // a stopped clock only freezes state, so clearing the bit resumes as it was
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < N; i++) begin
            st_next.en[i] = i_io_run && !i_stop[i];
            st_next.ok[i] = i_acc[i] && !i_stop[i];
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_clk_en = st_reg.en;
    assign o_acc_ok = st_reg.ok;
endmodule

// File: hdl/slpg_pkg.sv
/*
 sleep controller constants: mode codes, states, wake delays.
 assumes one clock; users write slpg_pkg::name.
*/
// Notes on behaviour
// - code 010 power-down, oscillator off
// - power-down wakes on listed sources only
// - power-down halts generated clocks
// - lost level wakes, no interrupt
// - power-down wake delay from fuses
// - code 011 power-save, timer2 runs
// - timer2 wake needs both enables
// - power-save clocks follow timer2 source
// - code 110 standby, six-cycle wake
// - code 111 extended standby, six cycles
// - stop bit freezes peripheral, blocks access
// - clearing stop bit resumes state
// - clock stop in active and idle
// - converter kept; restart gives extended
// - comparator off in deep modes unless on reference
// - fused brown-out stays on
// - reference on only when needed
// - enabled watchdog always runs
// - buffers off when io, adc stop
// - input-disable bits force buffers off
// - debug fuse keeps main clock
// - interrupt wake halts core four cycles
// - code 000 idle halts cpu, flash
// - code 001 also halts io
package slpg_pkg;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADCNR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam int STBY_WAKE_CYC = 6;
    localparam int CORE_HALT_CYC = 4;
    localparam int STARTUP_CYC_W = 16;
    localparam int NUM_PERIPH = 8;
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SLEEP = 5'h02,
        ST_START = 5'h04,
        ST_HALT = 5'h08,
        ST_RESUME = 5'h10
    } slpg_state_t;
endpackage

// File: hdl/slpg_sync.sv
/*
 two-flop synchroniser bank for wake sources and pins.
 assumes inputs are asynchronous to i_clk.
*/
`timescale 1ns/10ps
module slpg_sync #(
    parameter int W = 8
) (
    input wire logic i_clk,       // main clock
    input wire logic i_rst,       // sync reset
    input wire logic [W-1:0] i_d, // async inputs
    output logic [W-1:0] o_q      // synchronised
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } slpg_sync_t;
    slpg_sync_t st_reg, st_next;
    // first stage feeds only the second stage
    always_comb begin
        st_next = st_reg;
        st_next.s1 = i_d;
        st_next.s2 = st_reg.s1;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_q = st_reg.s2;
endmodule

// File: hdl/slpg_top.sv
/*
 sleep controller: mode decode, clock and power gating, wake timing.
 assumes a one-cycle i_sleep_exec pulse and an always-on I_CLK.
*/
`timescale 1ns/10ps
module slpg_top #(
    parameter int N = slpg_pkg::NUM_PERIPH
) (
    input wire logic I_CLK,                       // 10 MHz clock
    input wire logic I_RST,                       // sync reset, high
    input wire logic i_sleep_exec,                // sleep instruction pulse
    input wire logic i_sleep_entry_allow,         // entry allow bit
    input wire logic [2:0] i_sleep_mode_select,   // mode code
    input wire logic i_xtal_option,               // crystal/resonator clock chosen
    input wire logic [15:0] i_startup_cycles,     // wake delay from clock fuses
    input wire logic i_ext_irq_pin_a,             // pin a level (async)
    input wire logic i_ext_irq_pin_b,             // pin b level (async)
    input wire logic i_ext_irq_en_a,              // pin a level irq enabled
    input wire logic i_ext_irq_en_b,              // pin b level irq enabled
    input wire logic i_pin_change,                // pin change irq (async)
    input wire logic i_twi_match,                 // address match (async)
    input wire logic i_wdt_event,                 // watchdog irq (async)
    input wire logic i_reset_wake,                // any reset source (async)
    input wire logic i_other_irq,                 // any other enabled irq
    input wire logic i_t2_ovf,                    // timer2 overflow (async)
    input wire logic i_t2_cmp,                    // timer2 compare (async)
    input wire logic [1:0] i_timer2_irq_mask,     // ovf, cmp enables
    input wire logic i_global_irq_en,             // global irq flag
    input wire logic i_t2_async,                  // timer2 on async clock
    input wire logic i_t2_enabled,                // timer2 enabled
    input wire logic [N-1:0] i_peripheral_clock_stop, // clock-stop bits
    input wire logic [N-1:0] i_periph_access,     // register accesses
    input wire logic i_adc_enable,                // converter enabled
    input wire logic i_acmp_enable,               // comparator enabled
    input wire logic i_acmp_uses_ref,             // comparator uses reference
    input wire logic i_brownout_threshold_fuse,   // brown-out fused on
    input wire logic i_wdt_enable,                // watchdog enabled
    input wire logic i_onchip_debug_fuse,         // debug fuse
    input wire logic [7:0] i_digital_input_off_0, // input disable 0
    input wire logic [7:0] i_digital_input_off_1, // input disable 1
    input wire logic [15:0] i_wake_pin_mask,      // pins needed for wake
    output logic O_CPU_CLK_EN,                    // cpu clock run
    output logic O_FLASH_CLK_EN,                  // flash clock run
    output logic O_IO_CLK_EN,                     // io clock run
    output logic O_ADC_CLK_EN,                    // adc clock run
    output logic O_ASY_CLK_EN,                    // async timer clock run
    output logic O_MAIN_OSC_EN,                   // main oscillator run
    output logic O_TIMER_OSC_EN,                  // timer oscillator run
    output logic O_T2_SYNC_ONLY,                  // sync clock reaches timer2 only
    output logic [N-1:0] O_PERIPH_CLK_EN,         // per-peripheral clocks
    output logic [N-1:0] O_PERIPH_ACC_OK,         // accesses let through
    output logic O_ADC_POWER,                     // converter powered
    output logic O_ADC_EXTENDED,                  // next conversion extended
    output logic O_ACMP_POWER,                    // comparator powered
    output logic O_REF_POWER,                     // reference powered
    output logic O_BOD_POWER,                     // brown-out powered
    output logic O_WDT_RUN,                       // watchdog running
    output logic [15:0] O_INPUT_BUF_EN,           // digital input buffers
    output logic O_IRQ_TAKE,                      // one-cycle interrupt sample
    output logic O_SLEEPING,                      // core halted by sleep
    output logic [2:0] O_MODE                     // active sleep mode
);
    localparam int SW = slpg_pkg::STARTUP_CYC_W;
    localparam logic [SW-1:0] STBY_CNT = SW'(slpg_pkg::STBY_WAKE_CYC);
    localparam logic [SW-1:0] HALT_CNT = SW'(slpg_pkg::CORE_HALT_CYC);

    typedef struct packed {
        slpg_pkg::slpg_state_t state;
        logic [2:0] mode;
        logic [SW-1:0] cnt;
        logic irq_wake;
        logic cpu, flash, io, adc, asy, mosc, tosc, t2only;
        logic adc_pwr, adc_ext, acmp, ref_on, bod, wdt;
        logic [15:0] ibuf;
        logic take;
    } slpg_top_t;
    slpg_top_t st_reg, st_next;

    logic [8:0] async_raw;
    logic [8:0] async_s;
    logic [15:0] in_off;
    logic pa_s, pb_s, pc_s, twi_s, wdt_s, rst_s, oth_s, ovf_s, cmp_s;
    logic deep, save_like, keep_osc, t2_wake, lvl_wake, wake_any;
    logic [N-1:0] gate_en, gate_ok;

    // every wake source crosses two flops before any logic reads it
    assign async_raw = {i_t2_cmp, i_t2_ovf, i_other_irq, i_reset_wake,
                        i_wdt_event, i_twi_match, i_pin_change,
                        i_ext_irq_pin_b, i_ext_irq_pin_a};
    slpg_sync #(.W(9)) u_sync (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_d(async_raw),
        .o_q(async_s)
    );
    assign {cmp_s, ovf_s, oth_s, rst_s, wdt_s, twi_s, pc_s, pb_s, pa_s} = async_s;
    // input-disable bits as one vector, pin 0 at the bottom
    assign in_off = {i_digital_input_off_1, i_digital_input_off_0};

    slpg_gate #(.N(N)) u_gate (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_io_run(st_reg.io),
        .i_stop(i_peripheral_clock_stop),
        .i_acc(i_periph_access),
        .o_clk_en(gate_en),
        .o_acc_ok(gate_ok)
    );

    // mode classes of the latched mode
    always_comb begin
        deep = st_reg.mode[1];
        save_like = st_reg.mode[0];
        keep_osc = st_reg.mode[2];
        // in deep modes timer2 needs both its own enable and the global flag
        t2_wake = save_like && i_global_irq_en &&
                  ((ovf_s && i_timer2_irq_mask[0]) || (cmp_s && i_timer2_irq_mask[1]));
        lvl_wake = (pa_s && i_ext_irq_en_a) || (pb_s && i_ext_irq_en_b);
        wake_any = rst_s || wdt_s || twi_s || lvl_wake || pc_s ||
                   (deep ? t2_wake : (oth_s || (save_like && i_t2_async && (ovf_s || cmp_s))));
    end

    // next-state logic: sequencing plus the clock and power decode
    always_comb begin
        st_next = st_reg;
        st_next.take = 1'b0;
        case (st_reg.state)
            slpg_pkg::ST_RUN: begin
                if (i_sleep_exec && i_sleep_entry_allow) begin
                    case (i_sleep_mode_select)
                        slpg_pkg::MODE_IDLE, slpg_pkg::MODE_ADCNR,
                        slpg_pkg::MODE_PDOWN, slpg_pkg::MODE_PSAVE: begin
                            st_next.mode = i_sleep_mode_select;
                            st_next.state = slpg_pkg::ST_SLEEP;
                        end
                        slpg_pkg::MODE_STBY, slpg_pkg::MODE_XSTBY: begin
                            // without a crystal the fast wake cannot be met: stay awake
                            if (i_xtal_option) begin
                                st_next.mode = i_sleep_mode_select;
                                st_next.state = slpg_pkg::ST_SLEEP;
                            end
                        end
                        default: begin
                            st_next.state = slpg_pkg::ST_RUN;
                        end
                    endcase
                end
            end
            slpg_pkg::ST_SLEEP: begin
                if (wake_any) begin
                    st_next.irq_wake = !rst_s;
                    st_next.state = slpg_pkg::ST_START;
                    if (deep && keep_osc) begin
                        st_next.cnt = STBY_CNT;
                    end else if (deep) begin
                        st_next.cnt = i_startup_cycles;
                    end else begin
                        st_next.cnt = SW'(1);
                    end
                end
            end
            slpg_pkg::ST_START: begin
                if (st_reg.cnt <= SW'(1)) begin
                    st_next.cnt = HALT_CNT;
                    st_next.state = st_reg.irq_wake ? slpg_pkg::ST_HALT : slpg_pkg::ST_RESUME;
                end else begin
                    st_next.cnt = st_reg.cnt - SW'(1);
                end
            end
            slpg_pkg::ST_HALT: begin
                if (st_reg.cnt <= SW'(1)) begin
                    st_next.state = slpg_pkg::ST_RESUME;
                end else begin
                    st_next.cnt = st_reg.cnt - SW'(1);
                end
            end
            slpg_pkg::ST_RESUME: begin
                // in deep modes levels are re-checked now; a vanished level gives no interrupt
                st_next.take = st_reg.irq_wake && (wake_any || !deep);
                st_next.irq_wake = 1'b0;
                st_next.mode = slpg_pkg::MODE_RESET;
                st_next.state = slpg_pkg::ST_RUN;
            end
            default: begin
                st_next.state = slpg_pkg::ST_RUN;
            end
        endcase

        // clock domains per state of the sequencer
        if (st_next.state == slpg_pkg::ST_RUN) begin
            st_next.cpu = 1'b1;
            st_next.flash = 1'b1;
            st_next.io = 1'b1;
            st_next.adc = 1'b1;
            st_next.asy = 1'b1;
            st_next.mosc = 1'b1;
            st_next.tosc = i_t2_async;
        end else begin
            st_next.cpu = 1'b0;
            st_next.flash = 1'b0;
            st_next.io = !st_next.mode[1] && !st_next.mode[0];
            st_next.adc = !st_next.mode[1];
            // power-save keeps timer2 alive on whichever clock it uses
            st_next.asy = !st_next.mode[1] || (st_next.mode[0] && i_t2_async);
            st_next.tosc = i_t2_async && (!st_next.mode[1] || st_next.mode[0]);
            st_next.mosc = !st_next.mode[1] || st_next.mode[2] ||
                           (st_next.mode[0] && i_t2_enabled && !i_t2_async) ||
                           (st_next.state != slpg_pkg::ST_SLEEP);
        end
        if (i_onchip_debug_fuse) begin
            st_next.mosc = 1'b1;
        end
        st_next.t2only = (st_next.state == slpg_pkg::ST_SLEEP) && st_next.mode[1] &&
                         st_next.mode[0] && st_next.mosc;

        // analog and supervisory blocks
        st_next.adc_pwr = i_adc_enable;
        if (!i_adc_enable) begin
            st_next.adc_ext = 1'b1;
        end
        st_next.acmp = i_acmp_enable &&
                       (st_next.state == slpg_pkg::ST_RUN || !st_next.mode[1] ||
                        i_acmp_uses_ref);
        st_next.bod = i_brownout_threshold_fuse;
        st_next.ref_on = st_next.bod || st_next.adc_pwr ||
                         (st_next.acmp && i_acmp_uses_ref);
        st_next.wdt = i_wdt_enable;

        // input buffers: off when io and adc both stop, wake pins excepted
        for (int p = 0; p < 16; p++) begin
            st_next.ibuf[p] = ((st_next.io || st_next.adc) || i_wake_pin_mask[p]) &&
                              !in_off[p];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            st_reg <= '{state: slpg_pkg::ST_RUN, mode: slpg_pkg::MODE_RESET, cpu: 1'b1,
                        flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1, mosc: 1'b1,
                        adc_ext: 1'b1, ibuf: 16'hffff, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register and the gate's register
    assign O_CPU_CLK_EN = st_reg.cpu;
    assign O_FLASH_CLK_EN = st_reg.flash;
    assign O_IO_CLK_EN = st_reg.io;
    assign O_ADC_CLK_EN = st_reg.adc;
    assign O_ASY_CLK_EN = st_reg.asy;
    assign O_MAIN_OSC_EN = st_reg.mosc;
    assign O_TIMER_OSC_EN = st_reg.tosc;
    assign O_T2_SYNC_ONLY = st_reg.t2only;
    assign O_PERIPH_CLK_EN = gate_en;
    assign O_PERIPH_ACC_OK = gate_ok;
    assign O_ADC_POWER = st_reg.adc_pwr;
    assign O_ADC_EXTENDED = st_reg.adc_ext;
    assign O_ACMP_POWER = st_reg.acmp;
    assign O_REF_POWER = st_reg.ref_on;
    assign O_BOD_POWER = st_reg.bod;
    assign O_WDT_RUN = st_reg.wdt;
    assign O_INPUT_BUF_EN = st_reg.ibuf;
    assign O_IRQ_TAKE = st_reg.take;
    assign O_SLEEPING = (st_reg.state != slpg_pkg::ST_RUN);
    assign O_MODE = st_reg.mode;
endmodule

// File: sim/slpg_core_model.sv
/*
 core and peripheral side: sleep instructions and stop bits.
 assumes the bench calls its tasks between clock edges.
*/
`timescale 1ns/10ps
module slpg_core_model (
    input wire logic clk,                                 // main clock
    output logic sleep_exec,                              // sleep instruction pulse
    output logic entry_allow,                             // entry allow bit
    output logic [2:0] mode_sel,                          // mode code
    output logic [slpg_pkg::NUM_PERIPH-1:0] stop_bits,    // clock-stop bits
    output logic [slpg_pkg::NUM_PERIPH-1:0] access        // access attempts
);
    // accesses always pending, so blocking shows
    initial begin
        sleep_exec = 1'h0;
        entry_allow = 1'h0;
        mode_sel = 3'h0;
        stop_bits = '0;
        access = '1;
    end

    // allow, then the instruction; allow drops at once against stray re-entry
    task automatic sleep_cmd(input logic [2:0] m);
        @(negedge clk);
        mode_sel = m;
        entry_allow = 1'h1;
        @(negedge clk);
        sleep_exec = 1'h1;
        @(negedge clk);
        sleep_exec = 1'h0;
        entry_allow = 1'h0;
    endtask

    // the peripheral counts as idle before its clock stops
    task automatic periph(input int idx, input logic stop);
        @(negedge clk);
        stop_bits[idx] = stop;
    endtask
endmodule

// File: sim/slpg_top_assertions.sv
/*
 port checker for the sleep controller.
 assumes binding into slpg_top; one clock, sync active-high reset.
*/
`timescale 1ns/10ps
module slpg_chk #(
    parameter int N = 8
) (
    input wire logic I_CLK,                       // main clock
    input wire logic I_RST,                       // sync reset
    input wire logic i_sleep_exec,                // sleep instruction
    input wire logic i_sleep_entry_allow,         // entry allow
    input wire logic [2:0] i_sleep_mode_select,   // mode code
    input wire logic i_xtal_option,               // crystal chosen
    input wire logic i_acmp_uses_ref,             // comparator on reference
    input wire logic i_brownout_threshold_fuse,   // brown-out fused on
    input wire logic i_wdt_enable,                // watchdog enabled
    input wire logic [7:0] i_digital_input_off_0, // input disable 0
    input wire logic [7:0] i_digital_input_off_1, // input disable 1
    input wire logic [N-1:0] i_peripheral_clock_stop, // stop bits
    input wire logic O_CPU_CLK_EN,                // cpu clock
    input wire logic O_FLASH_CLK_EN,              // flash clock
    input wire logic O_IO_CLK_EN,                 // io clock
    input wire logic O_ADC_CLK_EN,                // adc clock
    input wire logic O_ASY_CLK_EN,                // async clock
    input wire logic O_MAIN_OSC_EN,               // main oscillator
    input wire logic [N-1:0] O_PERIPH_CLK_EN,     // peripheral clocks
    input wire logic [N-1:0] O_PERIPH_ACC_OK,     // accesses passed
    input wire logic O_ACMP_POWER,                // comparator power
    input wire logic O_BOD_POWER,                 // brown-out power
    input wire logic O_WDT_RUN,                   // watchdog run
    input wire logic [15:0] O_INPUT_BUF_EN,       // input buffers
    input wire logic O_IRQ_TAKE,                  // interrupt sample
    input wire logic O_SLEEPING,                  // core halted
    input wire logic [2:0] O_MODE                 // active mode
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    // entry, gating, refusal and keep-alive; input causes checked one edge later, sleep-state checks in the same cycle
    pdown_entry_a: assert property (i_sleep_exec && i_sleep_entry_allow && !O_SLEEPING
        && i_sleep_mode_select == slpg_pkg::MODE_PDOWN |=> O_SLEEPING
        && O_MODE == slpg_pkg::MODE_PDOWN && !O_CPU_CLK_EN && !O_FLASH_CLK_EN)
        else $error("power-down entry missed");
    pdown_clocks_a: assert property (O_SLEEPING && O_MODE == slpg_pkg::MODE_PDOWN
        && !O_MAIN_OSC_EN |-> !O_IO_CLK_EN && !O_ADC_CLK_EN && !O_ASY_CLK_EN)
        else $error("clock running in power-down");
    bad_code_a: assert property (i_sleep_exec && !O_SLEEPING && (i_sleep_mode_select[2:1] == 2'h2
        || (i_sleep_mode_select[2:1] == 2'h3 && !i_xtal_option)) |=> !O_SLEEPING)
        else $error("refused code entered sleep");
    stby_osc_a: assert property (O_SLEEPING && O_MODE[2] |-> O_MAIN_OSC_EN)
        else $error("standby oscillator stopped");
    wdt_kept_a: assert property (i_wdt_enable ##1 i_wdt_enable |-> O_WDT_RUN)
        else $error("watchdog stopped");
    bod_kept_a: assert property (i_brownout_threshold_fuse |=> O_BOD_POWER)
        else $error("brown-out dropped");
    ibuf_off_a: assert property (1'h1 |=> (O_INPUT_BUF_EN
        & $past({i_digital_input_off_1, i_digital_input_off_0})) == 16'h0)
        else $error("disabled buffer on");
    gate_stop_a: assert property (1'h1 |=> ((O_PERIPH_CLK_EN | O_PERIPH_ACC_OK)
        & $past(i_peripheral_clock_stop)) == '0)
        else $error("stopped peripheral live");
    acmp_off_a: assert property (O_SLEEPING && $past(O_SLEEPING) && O_MODE[1] && !O_CPU_CLK_EN
        && !$past(i_acmp_uses_ref) |-> !O_ACMP_POWER)
        else $error("comparator on in deep sleep");
    take_once_a: assert property (O_IRQ_TAKE |-> !O_SLEEPING ##1 !O_IRQ_TAKE)
        else $error("interrupt sampled twice");

    pdown_c: cover property (O_SLEEPING && O_MODE == slpg_pkg::MODE_PDOWN);
    stby_c: cover property (O_SLEEPING && O_MODE == slpg_pkg::MODE_XSTBY);
    take_c: cover property (O_IRQ_TAKE);
endmodule

bind slpg_top slpg_chk #(.N(N)) chk_u (.*);

// File: sim/tb_top.sv
/*
 self-checking bench for the sleep controller.
 assumes package, design, core model and checker compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
    localparam int N = slpg_pkg::NUM_PERIPH;
    int err_count = 0, checks_done = 0;
    logic I_CLK = 1'h0, I_RST = 1'h1, i_xtal_option = 1'h1, i_ext_irq_pin_a = 1'h0;
    logic i_ext_irq_pin_b = 1'h0, i_ext_irq_en_a = 1'h0, i_ext_irq_en_b = 1'h0;
    logic i_pin_change = 1'h0, i_twi_match = 1'h0, i_wdt_event = 1'h0, i_reset_wake = 1'h0;
    logic i_other_irq = 1'h0, i_t2_ovf = 1'h0, i_t2_cmp = 1'h0, i_global_irq_en = 1'h0;
    logic i_t2_async = 1'h1, i_t2_enabled = 1'h1, i_adc_enable = 1'h0, i_acmp_enable = 1'h0;
    logic i_acmp_uses_ref = 1'h0, i_brownout_threshold_fuse = 1'h0, i_wdt_enable = 1'h0;
    logic i_onchip_debug_fuse = 1'h0, i_sleep_exec, i_sleep_entry_allow;
    logic [1:0] i_timer2_irq_mask = 2'h0;
    logic [2:0] i_sleep_mode_select, O_MODE;
    logic [7:0] i_digital_input_off_0 = 8'h0, i_digital_input_off_1 = 8'h0;
    logic [15:0] i_startup_cycles = 16'h1, i_wake_pin_mask = 16'h0010, O_INPUT_BUF_EN;
    logic [N-1:0] i_peripheral_clock_stop, i_periph_access, O_PERIPH_CLK_EN, O_PERIPH_ACC_OK;
    logic O_CPU_CLK_EN, O_FLASH_CLK_EN, O_IO_CLK_EN, O_ADC_CLK_EN, O_ASY_CLK_EN;
    logic O_MAIN_OSC_EN, O_TIMER_OSC_EN, O_T2_SYNC_ONLY, O_ADC_POWER, O_ADC_EXTENDED;
    logic O_ACMP_POWER, O_REF_POWER, O_BOD_POWER, O_WDT_RUN, O_IRQ_TAKE, O_SLEEPING;
    logic n_took;
    int n1, n2;
    wire [7:0] dom = {O_CPU_CLK_EN, O_FLASH_CLK_EN, O_IO_CLK_EN, O_ADC_CLK_EN,
        O_MAIN_OSC_EN, O_TIMER_OSC_EN, O_ASY_CLK_EN, O_T2_SYNC_ONLY};

    slpg_top #(.N(N)) dut_u (.*);
    slpg_core_model core_u (.clk(I_CLK), .sleep_exec(i_sleep_exec),
        .entry_allow(i_sleep_entry_allow), .mode_sel(i_sleep_mode_select),
        .stop_bits(i_peripheral_clock_stop), .access(i_periph_access));

    always #50 I_CLK = ~I_CLK;

    task automatic print_verdict();
        $display("checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // waits for the core to run again, then watches a few cycles for the sample pulse
    task automatic wait_wake(output int n, output logic took);
        n = 0;
        took = 1'h0;
        while (O_SLEEPING !== 1'h0 && n < 300) begin
            @(negedge I_CLK);
            n++;
        end
        `CHK(n < 300, 1'h1, "no wake")
        if (n >= 300) begin
            print_verdict();
        end
        repeat (4) begin
            took |= (O_IRQ_TAKE === 1'h1);
            @(negedge I_CLK);
        end
    endtask

    // pin change held through the whole wake, so the interrupt must be taken
    task automatic wake_pc(output int n);
        logic took;
        i_pin_change = 1'h1;
        wait_wake(n, took);
        i_pin_change = 1'h0;
        `CHK(took, 1'h1, "pin change not taken")
        repeat (3) @(negedge I_CLK);
    endtask

    task automatic t_modes();
        logic [7:0] exp [6] = '{8'h3e, 8'h1e, 8'h00, 8'h06, 8'h08, 8'h0f};
        logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        for (int k = 0; k < 6; k++) begin
            core_u.sleep_cmd(code[k]);
            @(negedge I_CLK);
            `CHK(dom, exp[k], "domain enables")
            `CHK(O_MODE, code[k], "mode")
            `CHK(O_PERIPH_CLK_EN != '0, exp[k][5], "peripheral clocks")
            `CHK(O_INPUT_BUF_EN, exp[k][5:4] != 2'h0 ? 16'hffff : 16'h0010, "buffers")
            wake_pc(n1);
        end
    endtask

    task automatic t_timing();
        i_startup_cycles = 16'h1e;
        core_u.sleep_cmd(slpg_pkg::MODE_PDOWN);
        wake_pc(n1);
        core_u.sleep_cmd(slpg_pkg::MODE_STBY);
        wake_pc(n2);
        `CHK(n1 - n2, 24, "wake delay")
        i_startup_cycles = 16'h28;
        i_ext_irq_en_a = 1'h1;
        core_u.sleep_cmd(slpg_pkg::MODE_PDOWN);
        i_ext_irq_pin_a = 1'h1;
        repeat (4) @(negedge I_CLK);
        i_ext_irq_pin_a = 1'h0;
        wait_wake(n1, n_took);
        `CHK(n_took, 1'h0, "lost level taken")
    endtask

    task automatic t_filter();
        core_u.sleep_cmd(slpg_pkg::MODE_PDOWN);
        {i_other_irq, i_t2_ovf, i_timer2_irq_mask, i_global_irq_en} = 5'h1f;
        repeat (10) @(negedge I_CLK);
        `CHK(O_SLEEPING, 1'h1, "foreign source woke power-down")
        {i_other_irq, i_global_irq_en, i_timer2_irq_mask, i_reset_wake} = 5'h3;
        repeat (4) @(negedge I_CLK);
        i_reset_wake = 1'h0;
        wait_wake(n1, n_took);
        `CHK(n_took, 1'h0, "reset wake taken")
        core_u.sleep_cmd(slpg_pkg::MODE_PSAVE);
        repeat (10) @(negedge I_CLK);
        `CHK(O_SLEEPING, 1'h1, "timer woke without global enable")
        i_global_irq_en = 1'h1;
        wait_wake(n1, n_took);
        `CHK(n_took, 1'h1, "timer wake")
        {i_t2_ovf, i_global_irq_en} = 2'h0;
        for (int c = 4; c < 8; c++) begin
            i_xtal_option = 1'h0;
            core_u.sleep_cmd(3'(c));
            `CHK(O_SLEEPING, 1'h0, "refused code slept")
        end
        i_xtal_option = 1'h1;
    endtask

    task automatic t_power();
        core_u.periph(2, 1'h1);
        repeat (2) @(negedge I_CLK);
        `CHK(O_PERIPH_CLK_EN[3:2], 2'h2, "stop clock")
        `CHK(O_PERIPH_ACC_OK[3:2], 2'h2, "stop access")
        core_u.periph(2, 1'h0);
        repeat (2) @(negedge I_CLK);
        `CHK({O_PERIPH_CLK_EN[2], O_PERIPH_ACC_OK[2]}, 2'h3, "resume")
        {i_adc_enable, i_acmp_enable, i_brownout_threshold_fuse, i_wdt_enable} = 4'hf;
        i_digital_input_off_0 = 8'h05;
        core_u.sleep_cmd(slpg_pkg::MODE_PDOWN);
        @(negedge I_CLK);
        `CHK({O_ADC_POWER, O_ACMP_POWER, O_BOD_POWER, O_WDT_RUN, O_REF_POWER}, 5'h17, "keep")
        wake_pc(n1);
        `CHK(O_INPUT_BUF_EN[2:0], 3'h2, "input disable")
        {i_adc_enable, i_acmp_enable, i_brownout_threshold_fuse} = 3'h0;
        repeat (2) @(negedge I_CLK);
        `CHK({O_REF_POWER, O_ADC_EXTENDED}, 2'h1, "reference and restart")
        i_onchip_debug_fuse = 1'h1;
        core_u.sleep_cmd(slpg_pkg::MODE_PDOWN);
        @(negedge I_CLK);
        `CHK(O_MAIN_OSC_EN, 1'h1, "debug clock")
        wake_pc(n1);
    endtask

    initial begin
        repeat (20) @(negedge I_CLK);
        I_RST = 1'h0;
        repeat (3) @(negedge I_CLK);
        `CHK(dom, 8'hfe, "active enables")
        t_modes();
        t_timing();
        t_filter();
        t_power();
        print_verdict();
    end
endmodule
